// File: hw/pwm_clocking.v
// four-channel pwm with prescaled and scaled channel clocks, avalon slave
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "pwm_clocking_defines.vh"
module pwm_clocking #(
  parameter CHAN_W = 8          // bits per channel counter
) (
  input  wire        core_clk,            // bus clock, 10 MHz
  input  wire        rst,                 // synchronous reset, high
  input  wire [4:0]  address,             // avalon word address
  input  wire        read,                // avalon read request
  input  wire        write,               // avalon write request
  input  wire [31:0] writedata,           // avalon write data
  input  wire [3:0]  byteenable,          // avalon byte lanes
  output wire        waitrequest,         // avalon stall
  output reg  [31:0] readdata,            // avalon read data
  input  wire        special_mode_flag,   // high in special mode
  input  wire [3:0]  port_direction_bits, // general port direction
  input  wire [3:0]  port_data_bits,      // general port output data
  output reg  [3:0]  port_pin_out,        // pin output level
  output reg  [3:0]  port_pin_oe_n        // pin enable, low drives
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg              ack_q;
  reg [7:0]        clock_prescale_concat_q;
  reg [7:0]        clock_select_polarity_q;
  reg [3:0]        channel_enable_q;
  reg [6:0]        prescale_count_q;
  reg [7:0]        scale_value_q [0:1];
  reg [7:0]        scale_count_q [0:1];
  reg [1:0]        scale_half_q;
  reg              center_align_select_q;
  reg              scale_load_disable_q;
  reg [CHAN_W-1:0] cnt_q      [0:3];
  reg [CHAN_W-1:0] per_buf_q  [0:3];
  reg [CHAN_W-1:0] duty_buf_q [0:3];
  reg [CHAN_W-1:0] per_act_q  [0:3];
  reg [CHAN_W-1:0] duty_act_q [0:3];
  reg [3:0]        down_q;
  reg [3:0]        wave_q;
  reg [3:0]        started_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait state: data is registered before waitrequest drops
  assign waitrequest = (read | write) & ~ack_q;
  wire       wr_go  = write & ack_q & byteenable[0];
  wire [7:0] wdat   = writedata[7:0];
  wire       in_cnt = (address >= `REG_COUNTER_BASE) && (address < `REG_PERIOD_BASE);
  wire       in_per = (address >= `REG_PERIOD_BASE) && (address < `REG_DUTY_BASE);
  wire       in_dty = (address >= `REG_DUTY_BASE) && (address <= `REG_LAST);
  wire [4:0] off_c  = address - `REG_COUNTER_BASE;
  wire [4:0] off_p  = address - `REG_PERIOD_BASE;
  wire [4:0] off_d  = address - `REG_DUTY_BASE;
  wire [1:0] sub_c  = off_c[1:0];
  wire [1:0] sub_p  = off_p[1:0];
  wire [1:0] sub_d  = off_d[1:0];

  wire       cat23  = clock_prescale_concat_q[`FLD_CONCAT23];
  wire       cat01  = clock_prescale_concat_q[`FLD_CONCAT01];
  wire [2:0] pre_a  = clock_prescale_concat_q[`FLD_PRESCALE_A_LO +: 3];
  wire [2:0] pre_b  = clock_prescale_concat_q[`FLD_PRESCALE_B_LO +: 3];
  wire [3:0] csel   = clock_select_polarity_q[`FLD_CLOCK_SEL_LO +: 4];
  wire [3:0] pol    = clock_select_polarity_q[`FLD_POLARITY_LO +: 4];
  wire       any_en = |channel_enable_q;

  // ----------------------------------------------------------------
  // prescaled clocks A and B as one-cycle enables
  // ----------------------------------------------------------------
  // tick when the low field bits of the counter are all ones;
  // the enables are in step with core_clk, so gating stays edge-clean
  wire [6:0] mask_a = 7'h7F >> (3'd7 - pre_a);
  wire [6:0] mask_b = 7'h7F >> (3'd7 - pre_b);
  wire       tick_a = any_en & ((prescale_count_q & mask_a) == mask_a);
  wire       tick_b = any_en & ((prescale_count_q & mask_b) == mask_b);
  wire [1:0] tick_p = {tick_b, tick_a};

  // free-running counter, frozen while every channel is off
  always @(posedge core_clk) begin
    if (rst) begin
      prescale_count_q <= `RST_PRESCALE;
    end else if (wr_go && address == `REG_PRESCALE_COUNT && special_mode_flag) begin
      prescale_count_q <= wdat[6:0];
    end else if (any_en) begin
      prescale_count_q <= prescale_count_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // scaled clocks S0 and S1
  // ----------------------------------------------------------------
  wire [1:0] tick_s;
  wire [1:0] scale_zero;
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs = gs + 1) begin : g_scale
      assign scale_zero[gs] = (scale_count_q[gs] == 8'h00);
      // every second reload ends an S cycle: (value+1) * 2
      assign tick_s[gs] = tick_p[gs] & scale_zero[gs] & scale_half_q[gs];
    end
  endgenerate

  // down-counters; a value write reloads unless the test bit blocks it
  integer k;
  always @(posedge core_clk) begin
    if (rst) begin
      for (k = 0; k < 2; k = k + 1) begin
        scale_value_q[k] <= `RST_BYTE;
        scale_count_q[k] <= `RST_BYTE;
      end
      scale_half_q <= 2'b00;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        if (tick_p[k]) begin
          if (scale_zero[k]) begin
            scale_count_q[k] <= scale_value_q[k];
            scale_half_q[k]  <= ~scale_half_q[k];
          end else begin
            scale_count_q[k] <= scale_count_q[k] - 8'h01;
          end
        end
        if (wr_go && address == (`REG_SCALE_ZERO_VALUE + 2 * k)) begin
          scale_value_q[k] <= wdat;
          if (!(special_mode_flag && scale_load_disable_q)) begin
            scale_count_q[k] <= wdat;
            scale_half_q[k]  <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel clock, enable and pairing
  // ----------------------------------------------------------------
  // a joined pair runs on the odd channel's clock, enable and polarity
  reg [3:0] tick_c;
  reg [3:0] en_c;
  reg [3:0] wide_c;
  reg [3:0] idle_c;
  integer   i;
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      tick_c[i] = csel[i] ? tick_s[i/2] : tick_p[i/2];
      wide_c[i] = (i % 2 == 1) && ((i == 1) ? cat01 : cat23);
      idle_c[i] = (i % 2 == 0) && ((i == 0) ? cat01 : cat23);
      en_c[i]   = idle_c[i] ? channel_enable_q[i+1] : channel_enable_q[i];
    end
  end

  // ----------------------------------------------------------------
  // channel counters and double-buffered period and duty
  // ----------------------------------------------------------------
  // next count of every channel, worked out ahead of the edge
  reg [15:0] c16;
  reg [15:0] p16;
  reg [15:0] nxt_c [0:3];
  reg [3:0]  roll;
  reg [3:0]  dn;
  integer    h;
  always @* begin
    c16 = 16'h0000;
    p16 = 16'h0000;
    for (h = 0; h < 4; h = h + 1) begin
      if (wide_c[h]) begin
        c16 = {cnt_q[h-1], cnt_q[h]};
        p16 = {per_act_q[h-1], per_act_q[h]};
      end else begin
        c16 = {8'h00, cnt_q[h]};
        p16 = {8'h00, per_act_q[h]};
      end
      roll[h]  = 1'b0;
      dn[h]    = down_q[h];
      nxt_c[h] = 16'h0000;
      if (!center_align_select_q) begin
        roll[h]  = (c16 >= p16);
        nxt_c[h] = roll[h] ? 16'h0000 : c16 + 16'h0001;
      end else if (!down_q[h]) begin
        dn[h]    = (c16 >= p16) && (p16 != 16'h0000);
        nxt_c[h] = dn[h] ? c16 - 16'h0001 : ((p16 == 16'h0000) ? 16'h0000 : c16 + 16'h0001);
      end else begin
        roll[h]  = (c16 == 16'h0000);
        dn[h]    = ~roll[h];
        nxt_c[h] = roll[h] ? 16'h0001 : c16 - 16'h0001;
      end
    end
  end

  // counters, buffers and active latches
  integer    j;
  always @(posedge core_clk) begin
    if (rst) begin
      for (j = 0; j < 4; j = j + 1) begin
        cnt_q[j]      <= {CHAN_W{1'b0}};
        per_buf_q[j]  <= {CHAN_W{1'b0}};
        duty_buf_q[j] <= {CHAN_W{1'b0}};
        per_act_q[j]  <= {CHAN_W{1'b0}};
        duty_act_q[j] <= {CHAN_W{1'b0}};
      end
      down_q <= 4'h0;
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (wr_go && in_per && sub_p == j) begin
          per_buf_q[j] <= wdat;
        end
        if (wr_go && in_dty && sub_d == j) begin
          duty_buf_q[j] <= wdat;
        end
        // disabled: latches follow the buffer at once
        if (!en_c[j]) begin
          per_act_q[j]  <= (wr_go && in_per && sub_p == j) ? wdat : per_buf_q[j];
          duty_act_q[j] <= (wr_go && in_dty && sub_d == j) ? wdat : duty_buf_q[j];
          down_q[j]     <= 1'b0;
        end else if (tick_c[j] && !idle_c[j]) begin
          down_q[j] <= dn[j];
          cnt_q[j]  <= nxt_c[j][7:0];
          if (wide_c[j]) begin
            cnt_q[j-1] <= nxt_c[j][15:8];
          end
          // new values only at a period boundary
          if (roll[j]) begin
            per_act_q[j]  <= per_buf_q[j];
            duty_act_q[j] <= duty_buf_q[j];
            if (wide_c[j]) begin
              per_act_q[j-1]  <= per_buf_q[j-1];
              duty_act_q[j-1] <= duty_buf_q[j-1];
            end
          end
        end
        // counter write wins over counting and forces the latches
        if (wr_go && in_cnt && sub_c == j) begin
          cnt_q[j]      <= {CHAN_W{1'b0}};
          down_q[j]     <= 1'b0;
          per_act_q[j]  <= per_buf_q[j];
          duty_act_q[j] <= duty_buf_q[j];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // waveform compare
  // ----------------------------------------------------------------
  // start level is the polarity; it is flipped while the count is at or above duty
  reg [15:0] wc;
  reg [15:0] wp;
  reg [15:0] wd;
  reg [3:0]  lvl;
  reg [3:0]  pol_c;
  integer    m;
  always @* begin
    wc = 16'h0000;
    wp = 16'h0000;
    wd = 16'h0000;
    for (m = 0; m < 4; m = m + 1) begin
      pol_c[m] = idle_c[m] ? pol[m+1] : pol[m];
      if (wide_c[m]) begin
        wc = {cnt_q[m-1], cnt_q[m]};
        wp = {per_act_q[m-1], per_act_q[m]};
        wd = {duty_act_q[m-1], duty_act_q[m]};
      end else begin
        wc = {8'h00, cnt_q[m]};
        wp = {8'h00, per_act_q[m]};
        wd = {8'h00, duty_act_q[m]};
      end
      // duty at or above period never flips the output
      if (wd >= wp || wc < wd) begin
        lvl[m] = pol_c[m];
      end else begin
        lvl[m] = ~pol_c[m];
      end
    end
  end

  // odd channel of a joined pair drives the even pin
  integer w;
  always @(posedge core_clk) begin
    if (rst) begin
      wave_q    <= 4'h0;
      started_q <= 4'h0;
    end else begin
      for (w = 0; w < 4; w = w + 1) begin
        if (!en_c[w]) begin
          started_q[w] <= 1'b0;
        end else if (tick_c[w]) begin
          started_q[w] <= 1'b1;
        end
      end
      wave_q[0] <= cat01 ? lvl[1] : lvl[0];
      wave_q[1] <= lvl[1];
      wave_q[2] <= cat23 ? lvl[3] : lvl[2];
      wave_q[3] <= lvl[3];
    end
  end

  // ----------------------------------------------------------------
  // port pin takeover
  // ----------------------------------------------------------------
  // the absorbed odd pin of a pair falls back to the general port
  wire [3:0] pin_pwm = {started_q[3] & ~cat23, started_q[3] & cat23 | started_q[2] & ~cat23,
                        started_q[1] & ~cat01, started_q[1] & cat01 | started_q[0] & ~cat01};
  // a joined pair owns the even pin through the odd channel's enable
  wire [3:0] pin_own = {channel_enable_q[3] & ~cat23, cat23 ? channel_enable_q[3] : channel_enable_q[2],
                        channel_enable_q[1] & ~cat01, cat01 ? channel_enable_q[1] : channel_enable_q[0]};
  always @(posedge core_clk) begin
    if (rst) begin
      port_pin_out  <= 4'h0;
      port_pin_oe_n <= 4'hF;
    end else begin
      port_pin_out  <= (pin_pwm & wave_q) | (~pin_pwm & port_data_bits);
      port_pin_oe_n <= ~(pin_own | port_direction_bits);
    end
  end

  // ----------------------------------------------------------------
  // control registers and bus handshake
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      ack_q                   <= 1'b0;
      clock_prescale_concat_q <= `RST_BYTE;
      clock_select_polarity_q <= `RST_BYTE;
      channel_enable_q        <= 4'h0;
      center_align_select_q   <= 1'b0;
      scale_load_disable_q    <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
      // test bit lives only in special mode
      if (!special_mode_flag) begin
        scale_load_disable_q <= 1'b0;
      end
      if (wr_go) begin
        case (address)
          `REG_CLOCK_PRESCALE_CONCAT: clock_prescale_concat_q <= wdat;
          `REG_CLOCK_SELECT_POLARITY: clock_select_polarity_q <= wdat;
          `REG_CHANNEL_ENABLE:        channel_enable_q <= wdat[3:0];
          `REG_ALIGN_CONTROL:         center_align_select_q <= wdat[`FLD_CENTER_ALIGN];
          `REG_TEST_MODE_CONTROLS: begin
            if (special_mode_flag) begin
              scale_load_disable_q <= wdat[`FLD_SCALE_LOAD_DIS];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux captured in the wait cycle; unmapped reads give zero
  reg [7:0] rmux;
  always @* begin
    case (address)
      `REG_CLOCK_PRESCALE_CONCAT: rmux = clock_prescale_concat_q;
      `REG_CLOCK_SELECT_POLARITY: rmux = clock_select_polarity_q;
      `REG_CHANNEL_ENABLE:        rmux = {4'h0, channel_enable_q};
      `REG_PRESCALE_COUNT:        rmux = {1'b0, prescale_count_q};
      `REG_SCALE_ZERO_VALUE:      rmux = scale_value_q[0];
      `REG_SCALE_ZERO_COUNT:      rmux = scale_count_q[0];
      `REG_SCALE_ONE_VALUE:       rmux = scale_value_q[1];
      `REG_SCALE_ONE_COUNT:       rmux = scale_count_q[1];
      `REG_ALIGN_CONTROL:         rmux = {7'h00, center_align_select_q};
      `REG_TEST_MODE_CONTROLS:    rmux = {7'h00, scale_load_disable_q};
      default: begin
        if (in_cnt) begin
          rmux = cnt_q[sub_c];
        end else if (in_per) begin
          rmux = per_buf_q[sub_p];
        end else if (in_dty) begin
          rmux = duty_buf_q[sub_d];
        end else begin
          rmux = 8'h00;
        end
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (read && !ack_q) begin
      readdata <= {24'h000000, rmux};
    end
  end

endmodule // pwm_clocking

// File: pkg/pwm_clocking_defines.vh
// register map, field layout and reset values of the four-channel pwm block
// What this block does
// - four 8-bit channels, pairs join to 16
// - enabled channel buffers period/duty until rollover
// - disabled channel writes reach active latch directly
// - counter write clears counter, latches buffers
// - enable forces pin output, direction bit untouched
// - pair 2/3 joins, channel 2 pin, ch3 clock
// - pair 0/1 joins, channel 0 pin, ch1 clock
// - clock A is bus clock over 2^field
// - clock B uses same encoding as A
// - per-channel select: prescaled or scaled clock
// - polarity sets start level of each period
// - duty counts low or high time per polarity
// - output appears at next selected clock tick
// - prescaler stops when all disabled; edge-clean gating
// - 7-bit prescaler, read anytime, special-mode write
// - scale write loads counter unless test bit
// - S0/S1 clock is A/B over (value+1) over 2
// - scale counter counts down, reloads at zero
// - left: period match clears; center: reverses
// - duty match toggles; duty>=period never toggles
// - alignment bit picks left or center mode
// - test bit suppresses scale counter load
`ifndef PWM_CLOCKING_DEFINES_VH
`define PWM_CLOCKING_DEFINES_VH
// ----------------------------------------------------------------
// word indices on the avalon slave
// ----------------------------------------------------------------
`define REG_CLOCK_PRESCALE_CONCAT 5'h00
`define REG_CLOCK_SELECT_POLARITY 5'h01
`define REG_CHANNEL_ENABLE        5'h02
`define REG_PRESCALE_COUNT        5'h03
`define REG_SCALE_ZERO_VALUE      5'h04
`define REG_SCALE_ZERO_COUNT      5'h05
`define REG_SCALE_ONE_VALUE       5'h06
`define REG_SCALE_ONE_COUNT       5'h07
`define REG_ALIGN_CONTROL         5'h08
`define REG_TEST_MODE_CONTROLS    5'h09
`define REG_COUNTER_BASE          5'h0A
`define REG_PERIOD_BASE           5'h0E
`define REG_DUTY_BASE             5'h12
`define REG_LAST                  5'h15
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLD_CONCAT23      7
`define FLD_CONCAT01      6
`define FLD_PRESCALE_A_LO 3
`define FLD_PRESCALE_B_LO 0
`define FLD_CLOCK_SEL_LO  4
`define FLD_POLARITY_LO   0
`define FLD_CENTER_ALIGN  0
`define FLD_SCALE_LOAD_DIS 0
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_PRESCALE 7'h00
`endif

// File: tb/pwm_clocking_bench.sv
// self-checking bench for the four-channel pwm block
`timescale 1ns/1ns
`include "pwm_clocking_defines.vh"
module pwm_clocking_bench;
  logic        core_clk;
  logic        rst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  wire         waitrequest;
  wire  [31:0] readdata;
  logic        special_mode_flag;
  logic [3:0]  port_direction_bits;
  logic [3:0]  port_data_bits;
  wire  [3:0]  port_pin_out;
  wire  [3:0]  port_pin_oe_n;
  logic [31:0] rdat;
  logic [31:0] keep;
  int          mismatches;
  int          checks;
  int          cycles;

  pwm_clocking i_pwm_clocking (
    .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
    .readdata(readdata), .special_mode_flag(special_mode_flag),
    .port_direction_bits(port_direction_bits), .port_data_bits(port_data_bits),
    .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the run needs some 3000 cycles, so 20000 means a hang
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // avalon master: hold until stall seen low, then release
  // ----------------------------------------------------------------
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    write      <= is_wr;
    read       <= ~is_wr;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rdat = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    check(rdat, exp);
  endtask

  // count high cycles and rising edges of one pin over n cycles
  task automatic measure(input int pin, input int n, output int hi, output int rise);
    logic prev;
    hi = 0;
    rise = 0;
    @(posedge core_clk);
    prev = port_pin_out[pin];
    repeat (n) begin
      @(posedge core_clk);
      if (port_pin_out[pin] === 1'b1) hi++;
      if (port_pin_out[pin] === 1'b1 && prev === 1'b0) rise++;
      prev = port_pin_out[pin];
    end
  endtask

  // program one waveform; n spans ten periods so phase cannot matter
  task automatic run_case(input int ch, input int pin, input logic [7:0] cfg0, input logic [7:0] cfg1,
                          input logic [7:0] al, input logic [7:0] per, input logic [7:0] duty,
                          input logic [7:0] en, input int n, input int exp_hi, input int exp_rise);
    int hi;
    int rise;
    for (int i = 0; i < 4; i++) begin
      wr(`REG_PERIOD_BASE + 5'(i), 8'h00);
      wr(`REG_DUTY_BASE + 5'(i), 8'h00);
    end
    wr(`REG_CLOCK_PRESCALE_CONCAT, cfg0);
    wr(`REG_CLOCK_SELECT_POLARITY, cfg1);
    wr(`REG_ALIGN_CONTROL, al);
    wr(`REG_PERIOD_BASE + 5'(ch), per);
    wr(`REG_DUTY_BASE + 5'(ch), duty);
    wr(`REG_CHANNEL_ENABLE, en);
    repeat (n / 5) @(posedge core_clk);
    check(32'(port_pin_oe_n[pin]), 32'h0);
    if (ch != pin) check(32'(port_pin_oe_n[ch]), 32'h1);
    measure(pin, n, hi, rise);
    if (exp_hi >= 0) check(32'(hi), 32'(exp_hi));
    check(32'(rise), 32'(exp_rise));
    wr(`REG_CHANNEL_ENABLE, 8'h00);
    @(posedge core_clk);
    check(32'(port_pin_oe_n), 32'hF);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    special_mode_flag = 1'b0;
    port_direction_bits = 4'h0;
    port_data_bits = 4'hA;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // every control register, prescaler and scale counter clear after reset
    for (int a = 0; a < 10; a++) rd_chk(5'(a), 32'h0);
    check(32'(port_pin_oe_n), 32'hF);
    wr(`REG_CLOCK_PRESCALE_CONCAT, 8'hA5);
    rd_chk(`REG_CLOCK_PRESCALE_CONCAT, 32'hA5);
    wr(`REG_CLOCK_SELECT_POLARITY, 8'h5A);
    rd_chk(`REG_CLOCK_SELECT_POLARITY, 32'h5A);
    bus(1'b1, `REG_CLOCK_PRESCALE_CONCAT, 8'h00, 4'hE);
    rd_chk(`REG_CLOCK_PRESCALE_CONCAT, 32'hA5);
    wr(`REG_CLOCK_PRESCALE_CONCAT, 8'h00);
    wr(`REG_CLOCK_SELECT_POLARITY, 8'h00);
    wr(5'h16, 8'hFF);
    rd_chk(5'h16, 32'h0);
    rd_chk(5'h1F, 32'h0);
    wr(`REG_PERIOD_BASE + 5'h2, 8'h3C);
    rd_chk(`REG_PERIOD_BASE + 5'h2, 32'h3C);
    wr(`REG_COUNTER_BASE + 5'h1, 8'h33);
    rd_chk(`REG_COUNTER_BASE + 5'h1, 32'h0);
    // prescaler writes only land in special mode
    wr(`REG_PRESCALE_COUNT, 8'h55);
    rd_chk(`REG_PRESCALE_COUNT, 32'h0);
    special_mode_flag <= 1'b1;
    wr(`REG_PRESCALE_COUNT, 8'h12);
    rd_chk(`REG_PRESCALE_COUNT, 32'h12);
    wr(`REG_PRESCALE_COUNT, 8'h00);
    wr(`REG_TEST_MODE_CONTROLS, 8'h01);
    wr(`REG_SCALE_ZERO_VALUE, 8'h07);
    rd_chk(`REG_SCALE_ZERO_COUNT, 32'h0);
    wr(`REG_TEST_MODE_CONTROLS, 8'h00);
    special_mode_flag <= 1'b0;
    wr(`REG_TEST_MODE_CONTROLS, 8'h01);
    rd_chk(`REG_TEST_MODE_CONTROLS, 32'h0);
    wr(`REG_SCALE_ZERO_VALUE, 8'h07);
    rd_chk(`REG_SCALE_ZERO_COUNT, 32'h07);
    port_direction_bits <= 4'h5;
    repeat (2) @(posedge core_clk);
    check(32'(port_pin_oe_n), 32'hA);
    port_direction_bits <= 4'h0;
    // scale of one makes each scaled clock a quarter of its source
    wr(`REG_SCALE_ZERO_VALUE, 8'h01);
    wr(`REG_SCALE_ONE_VALUE, 8'h01);
    run_case(0, 0, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 50, 40, 10);
    run_case(0, 0, 8'h00, 8'h01, 8'h00, 8'h04, 8'h01, 8'h01, 50, 10, 10);
    run_case(0, 0, 8'h08, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 100, 80, 10);
    run_case(0, 0, 8'h18, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 400, 320, 10);
    run_case(0, 0, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h01, 50, 0, 0);
    run_case(0, 0, 8'h00, 8'h10, 8'h00, 8'h04, 8'h01, 8'h01, 200, 160, 10);
    run_case(2, 2, 8'h01, 8'h00, 8'h00, 8'h04, 8'h01, 8'h04, 100, 80, 10);
    run_case(3, 3, 8'h00, 8'h80, 8'h00, 8'h04, 8'h01, 8'h08, 200, 160, 10);
    run_case(0, 0, 8'h00, 8'h00, 8'h01, 8'h04, 8'h01, 8'h01, 80, 70, 10);
    run_case(1, 0, 8'h40, 8'h00, 8'h00, 8'h04, 8'h01, 8'h02, 50, 40, 10);
    run_case(3, 2, 8'h80, 8'h00, 8'h00, 8'h04, 8'h01, 8'h08, 50, 40, 10);
    // old period of 255 stays live until rollover, then 2 takes over
    wr(`REG_CLOCK_PRESCALE_CONCAT, 8'h00);
    wr(`REG_PERIOD_BASE, 8'hFF);
    wr(`REG_CHANNEL_ENABLE, 8'h01);
    wr(`REG_PERIOD_BASE, 8'h02);
    repeat (10) @(posedge core_clk);
    bus(1'b0, `REG_COUNTER_BASE, 8'h00, 4'hF);
    check(32'(rdat > 32'h2), 32'h1);
    repeat (300) @(posedge core_clk);
    bus(1'b0, `REG_COUNTER_BASE, 8'h00, 4'hF);
    check(32'(rdat <= 32'h2), 32'h1);
    wr(`REG_CHANNEL_ENABLE, 8'h00);
    // with every channel off the prescaler must hold still
    bus(1'b0, `REG_PRESCALE_COUNT, 8'h00, 4'hF);
    keep = rdat;
    repeat (10) @(posedge core_clk);
    rd_chk(`REG_PRESCALE_COUNT, keep);
    stop_test();
  end
endmodule // pwm_clocking_bench

// File: tb/pwm_clocking_monitor.sv
// assertion checker watching the pwm block's bus and pin ports
`timescale 1ns/1ns
module pwm_clocking_monitor #(
  parameter CHAN_W = 8 // bits per channel counter
) (
  input wire        core_clk,            // bus clock
  input wire        rst,                 // sync reset, high
  input wire [4:0]  address,             // word address
  input wire        read,                // read request
  input wire        write,               // write request
  input wire [31:0] writedata,           // write data
  input wire [3:0]  byteenable,          // byte lanes
  input wire        waitrequest,         // stall
  input wire [31:0] readdata,            // read data
  input wire        special_mode_flag,   // special mode
  input wire [3:0]  port_direction_bits, // port direction
  input wire [3:0]  port_data_bits,      // port data
  input wire [3:0]  port_pin_out,        // pin level
  input wire [3:0]  port_pin_oe_n        // pin enable, low drives
);
  // ----------------------------------------------------------------
  // one clock domain, so clocking and reset are given once
  // ----------------------------------------------------------------
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wait_one_a: assert property ($rose(read | write) |-> waitrequest ##1 !waitrequest)
    else $error("request not answered after one wait state");
  idle_nowait_a: assert property (!(read | write) |-> !waitrequest)
    else $error("stall raised without a request");
  stall_once_a: assert property (waitrequest |=> !waitrequest)
    else $error("stall held for two cycles");
  upper_zero_a: assert property (readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  reset_state_a: assert property ($fell(rst) |-> port_pin_oe_n == 4'hF && port_pin_out == 4'h0)
    else $error("pins not released by reset");
  // a set direction bit must always leave its pin driven
  dir_drive_a: assert property (!$past(rst) |-> (port_pin_oe_n & $past(port_direction_bits)) == 4'h0)
    else $error("pin with direction bit set not driven");
  unmapped_zero_a: assert property (read && !waitrequest && address > 5'h15 |-> readdata == 32'h0)
    else $error("unmapped read returned data");
  // read data only moves on the first cycle of a read
  readdata_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data changed without a read");
endmodule // pwm_clocking_monitor

bind pwm_clocking pwm_clocking_monitor #(.CHAN_W(CHAN_W)) i_pwm_clocking_monitor (
  .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .readdata(readdata), .special_mode_flag(special_mode_flag),
  .port_direction_bits(port_direction_bits), .port_data_bits(port_data_bits),
  .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n));
